/* tb/editor_checker.sv */
// port assertions for the setup editor
`timescale 1ns/1ns
module editor_checker #(
  parameter int COLS = 72,
  parameter int NSET = 100,
  parameter int NOTICE_CYC = 20
) (
  // clock, reset, apb
  input wire logic pclk, presetn, psel, penable, pready,
  // keys and pen
  input wire logic entry_valid, key_memory, key_relays, key_enter, key_open, key_close,
  input wire logic key_clear, key_save, key_apply, key_auto, pen_press,
  input wire logic [8:0] entry_num,
  input wire logic [2:0] entry_row,
  input wire editor_pkg::pen_t pen_kind,
  // image and indicators
  input wire logic [8*COLS-1:0] view, relays,
  input wire logic [15:0] mb_rows, bm_rows,
  input wire logic ind_mem, ind_rly, ind_edt, ind_auto, note_bad, note_pen,
  input wire logic [6:0] mem_step, rly_step
);
  localparam int NMAX = NOTICE_CYC + 2;
  wire logic src_key = key_memory | key_relays | key_save | key_apply | key_enter;
  wire logic xp_ok = entry_valid && entry_num >= 9'h001 && entry_num <= 9'(COLS);
  wire logic [9:0] xp_idx = 10'(entry_row) * 10'(COLS) + 10'(entry_num) - 10'h001;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_one_source: assert property (
    $countones({ind_mem, ind_rly, ind_edt}) == 1 || (ind_auto && ind_rly && !ind_mem))
    else $error("source indicators not one-hot");
  chk_mark_excl: assert property ((mb_rows & bm_rows) == 16'h0000)
    else $error("row marked in both modes");
  chk_apb_answer: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("apb answer not one access cycle");
  chk_clear_view: assert property (
    key_clear |=> view == '0 && (!$past(ind_auto) || relays == '0))
    else $error("clear left crosspoints on");
  chk_close_set: assert property (
    key_close && xp_ok |=> view[$past(xp_idx)] && (!$past(ind_auto) || relays[$past(xp_idx)]))
    else $error("close did not set crosspoint");
  chk_open_clear: assert property (key_open && xp_ok |=> !view[$past(xp_idx)])
    else $error("open did not clear crosspoint");
  chk_edit_shows: assert property (
    (key_clear || ((key_close || key_open) && xp_ok)) && !ind_auto
      |-> ##2 (ind_edt && !ind_mem && !ind_rly))
    else $error("edit did not light edited indicator");
  chk_scroll_idle: assert property (
    ind_edt && !ind_rly && !src_key && !$past(src_key)
      |=> $stable(mem_step) && $stable(rly_step))
    else $error("step moved while edited");
  chk_bad_entry: assert property (
    key_memory && entry_valid && (entry_num > 9'(NSET) || entry_num == 9'h000)
      |=> note_bad && $stable(mem_step) && $stable(view))
    else $error("bad location not refused");
  chk_pen_miss: assert property (
    pen_press && pen_kind == editor_pkg::PEN_MISS |=> note_pen && $stable(view))
    else $error("pen miss not noticed");
  chk_notice_ends: assert property ($rose(note_pen) |-> ##[1:NMAX] !note_pen)
    else $error("pen notice did not end");
  chk_live_toggle: assert property (key_auto |=> ind_auto != $past(ind_auto))
    else $error("live-apply did not toggle");
  chk_reset_vals: assert property (
    $rose(presetn) |-> mem_step == 7'h01 && rly_step == 7'h00 && ind_rly && !ind_auto)
    else $error("reset values wrong");
  cover property (key_save ##2 ind_mem);
  cover property (ind_auto && ind_rly && ind_edt);
  cover property (pen_press && pen_kind == editor_pkg::PEN_XP);
endmodule : editor_checker
bind crosspoint_setup_editor editor_checker #(.COLS(COLS), .NSET(NSET),
  .NOTICE_CYC(NOTICE_CYC)) chk (.*);

/* tb/relay_side_model.sv */
// outside side: relay changes and stored-setup writes from the bus
`timescale 1ns/1ns
module relay_side_model #(
  parameter int COLS = 72
) (
  // clock
  input wire logic pclk,
  // stored-setup writes
  output logic bus_mem_we,
  output logic [6:0] bus_mem_loc,
  output logic [8*COLS-1:0] bus_mem_data,
  // relay changes
  output logic relay_load,
  output logic [8*COLS-1:0] relay_data
);
  initial begin
    bus_mem_we = 1'b0;
    bus_mem_loc = 7'h00;
    bus_mem_data = '0;
    relay_load = 1'b0;
    relay_data = '0;
  end
  // one-cycle pulses; data inverted once no longer qualified
  task automatic write_setup(input logic [6:0] loc, input logic [8*COLS-1:0] d);
    @(posedge pclk);
    bus_mem_we <= 1'b1;
    bus_mem_loc <= loc;
    bus_mem_data <= d;
    @(posedge pclk);
    bus_mem_we <= 1'b0;
    bus_mem_loc <= ~loc;
    bus_mem_data <= ~d;
  endtask : write_setup
  task automatic load_relays(input logic [8*COLS-1:0] d);
    @(posedge pclk);
    relay_load <= 1'b1;
    relay_data <= d;
    @(posedge pclk);
    relay_load <= 1'b0;
    relay_data <= ~d;
  endtask : load_relays
endmodule : relay_side_model

/* tb/tb.sv */
// self-checking bench for the setup editor
`timescale 1ns/1ns
`include "editor_regs.svh"
`define CHK(n, e, a) begin compares++; if ((a) !== (e)) begin err_count++; \
  $display("unexpected %s exp %0h got %0h", n, e, a); end end
module tb;
  localparam int MEM = 0, RLY = 1, ENT = 2, OPN = 3, CLS = 4, CLR = 5, SAV = 6, APL = 7;
  localparam int AUT = 8, MBK = 9, BMK = 10;
  localparam logic [575:0] PA = {72{8'h5a}}, PB = {72{8'h3c}}, PC = {72{8'h0f}};
  localparam logic [575:0] XB = 576'h1 << 215;
  logic pclk, presetn, psel, penable, pwrite, entry_valid, entry_blk, scroll_up, scroll_dn;
  logic pen_press, pen_blk, pready, pslverr, ind_mem, ind_rly, ind_edt, ind_auto;
  logic note_bad, note_pen, bus_mem_we, relay_load, rerr, s0, s1, allr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [8:0] entry_num, pen_col;
  logic [2:0] entry_row, pen_row;
  logic [10:0] keys;
  logic [6:0] mem_step, rly_step, bus_mem_loc;
  logic [575:0] view, relays, bus_mem_data, relay_data;
  logic [15:0] mb_rows, bm_rows;
  editor_pkg::pen_t pen_kind;
  int err_count, compares;
  crosspoint_setup_editor #(.NOTICE_CYC(20), .REPEAT_CYC(8),
    .BLINK_CYC(4)) dut (.*, .key_memory(keys[MEM]), .key_relays(keys[RLY]),
    .key_enter(keys[ENT]), .key_open(keys[OPN]), .key_close(keys[CLS]),
    .key_clear(keys[CLR]), .key_save(keys[SAV]), .key_apply(keys[APL]),
    .key_auto(keys[AUT]), .key_mb(keys[MBK]), .key_bm(keys[BMK]));
  relay_side_model #(.COLS(72)) side (.*);
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic conclude;
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : conclude
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rd = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 16) begin
      err_count++;
      conclude();
    end
  endtask : apb
  task automatic idle;
    @(posedge pclk);
    #1;
  endtask : idle
  // key pulse with entry; returns once indicators have settled
  task automatic press(input int k, input logic v, input logic [8:0] n, input logic [2:0] r,
    input logic b);
    @(posedge pclk);
    keys <= 11'h001 << k;
    entry_valid <= v;
    entry_num <= n;
    entry_row <= r;
    entry_blk <= b;
    @(posedge pclk);
    keys <= 11'h000;
    entry_valid <= 1'b0;
    idle();
  endtask : press
  task automatic pen(input editor_pkg::pen_t k, input logic [2:0] r, input logic b,
    input logic [8:0] c);
    @(posedge pclk);
    pen_press <= 1'b1;
    pen_kind <= k;
    pen_row <= r;
    pen_blk <= b;
    pen_col <= c;
    @(posedge pclk);
    pen_press <= 1'b0;
    idle();
  endtask : pen
  task automatic scroll(input logic up, input int cyc);
    @(posedge pclk);
    scroll_up <= up;
    scroll_dn <= !up;
    repeat (cyc) @(posedge pclk);
    scroll_up <= 1'b0;
    scroll_dn <= 1'b0;
    idle();
  endtask : scroll
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {presetn, psel, penable, pwrite, entry_valid, entry_blk, scroll_up, scroll_dn} = 8'h00;
    {pen_press, pen_blk, paddr, pwdata, entry_num, pen_col, entry_row, pen_row} = 70'h0;
    keys = 11'h000;
    pen_kind = editor_pkg::PEN_MISS;
    err_count = 0;
    compares = 0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `OFF_STATUS, 32'h0);
    `CHK("status", 32'h0002_0001, rd)
    apb(1'b0, 12'h00c, 32'h0);
    `CHK("slverr", 1'b1, rerr)
    side.write_setup(7'h01, PA);
    side.write_setup(7'h05, PB);
    idle();
    `CHK("view", 576'h0, view)
    press(MEM, 1'b1, 9'h005, 3'h0, 1'b0);
    `CHK("view", PB, view)
    `CHK("mem_step", 7'h05, mem_step)
    `CHK("src", 3'b100, {ind_mem, ind_rly, ind_edt})
    side.write_setup(7'h05, PA);
    idle();
    `CHK("view", PA, view)
    side.load_relays(PC);
    idle();
    `CHK("view", PA, view)
    `CHK("relays", PC, relays)
    press(MEM, 1'b1, 9'h065, 3'h0, 1'b0);
    `CHK("note_bad", 1'b1, note_bad)
    `CHK("mem_step", 7'h05, mem_step)
    press(MEM, 1'b1, 9'h001, 3'h0, 1'b0);
    scroll(1'b0, 1);
    `CHK("mem_step", 7'h64, mem_step)
    scroll(1'b1, 12);
    `CHK("mem_step", 7'h02, mem_step)
    press(ENT, 1'b1, 9'h005, 3'h0, 1'b0);
    `CHK("view", PA, view)
    press(CLS, 1'b1, 9'h048, 3'h2, 1'b0);
    `CHK("view", PA | XB, view)
    `CHK("src", 3'b001, {ind_mem, ind_rly, ind_edt})
    scroll(1'b1, 1);
    `CHK("mem_step", 7'h05, mem_step)
    press(SAV, 1'b1, 9'h007, 3'h0, 1'b0);
    `CHK("save", 10'h207, {ind_mem, ind_rly, ind_edt, mem_step})
    press(SAV, 1'b1, 9'h000, 3'h0, 1'b0);
    `CHK("save bad", 8'h87, {note_bad, mem_step})
    press(MEM, 1'b0, 9'h000, 3'h0, 1'b0);
    `CHK("view", PA | XB, view)
    press(APL, 1'b0, 9'h000, 3'h0, 1'b0);
    `CHK("relays", PA | XB, relays)
    `CHK("apply", 10'h207, {ind_mem, ind_rly, ind_edt, rly_step})
    press(OPN, 1'b1, 9'h048, 3'h2, 1'b0);
    `CHK("view", PA, view)
    `CHK("src", 3'b001, {ind_mem, ind_rly, ind_edt})
    press(RLY, 1'b1, 9'h000, 3'h0, 1'b0);
    `CHK("view", PA | XB, view)
    `CHK("rly_step", 7'h00, rly_step)
    side.load_relays(PC);
    idle();
    `CHK("view", PC, view)
    scroll(1'b1, 1);
    `CHK("relays", PA, relays)
    scroll(1'b0, 1);
    `CHK("step 0", {7'h00, PA}, {rly_step, relays})
    scroll(1'b0, 1);
    `CHK("step 100", {7'h64, 576'h0}, {rly_step, relays})
    press(RLY, 1'b1, 9'h001, 3'h0, 1'b0);
    press(AUT, 1'b0, 9'h000, 3'h0, 1'b0);
    `CHK("ind_auto", 1'b1, ind_auto)
    press(CLS, 1'b1, 9'h001, 3'h0, 1'b0);
    `CHK("relays", PA | 576'h1, relays)
    {s0, s1, allr} = 3'b001;
    repeat (12) begin
      @(posedge pclk);
      s0 |= !ind_edt;
      s1 |= ind_edt;
      allr &= ind_rly;
    end
    `CHK("blink", 3'b111, {s0, s1, allr})
    press(CLR, 1'b0, 9'h000, 3'h0, 1'b0);
    `CHK("clear", 1152'h0, {view, relays})
    press(MEM, 1'b1, 9'h005, 3'h0, 1'b0);
    `CHK("live", {7'h05, PA}, {rly_step, relays})
    press(MBK, 1'b1, 9'h000, 3'h3, 1'b0);
    `CHK("mb_rows", 16'h0008, mb_rows)
    press(BMK, 1'b1, 9'h000, 3'h3, 1'b0);
    `CHK("marks", 32'h0008_0000, {bm_rows, mb_rows})
    press(MBK, 1'b1, 9'h000, 3'h3, 1'b1);
    pen(editor_pkg::PEN_MB, 3'h3, 1'b0, 9'h000);
    `CHK("marks", 32'h0000_0808, {bm_rows, mb_rows})
    pen(editor_pkg::PEN_MISS, 3'h0, 1'b0, 9'h000);
    `CHK("note_pen", 17'h10808, {note_pen, mb_rows})
    pen(editor_pkg::PEN_XP, 3'h0, 1'b0, 9'h002);
    `CHK("view", PA & ~576'h2, view)
    apb(1'b0, `OFF_MARKS, 32'h0);
    `CHK("marks reg", 32'h0000_0808, rd)
    pen(editor_pkg::PEN_BM, 3'h3, 1'b1, 9'h000);
    `CHK("pen marks", 32'h0800_0008, {bm_rows, mb_rows})
    apb(1'b1, `OFF_UNITS, 32'h0000_0002);
    apb(1'b0, `OFF_UNITS, 32'h0);
    `CHK("units", 32'h0000_0002, rd)
    repeat (25) @(posedge pclk);
    press(CLS, 1'b1, 9'h064, 3'h0, 1'b0);
    `CHK("col 100", {1'b0, PA & ~576'h2}, {note_bad, view})
    press(CLS, 1'b1, 9'h091, 3'h0, 1'b0);
    `CHK("col 145", 1'b1, note_bad)
    press(APL, 1'b0, 9'h000, 3'h0, 1'b0);
    `CHK("apply edt", 10'h105, {ind_mem, ind_rly, ind_edt, rly_step})
    press(ENT, 1'b1, 9'h001, 3'h0, 1'b0);
    `CHK("enter rly", {7'h01, PA}, {rly_step, relays})
    conclude();
  end
endmodule : tb

/* verilog/crosspoint_setup_editor.sv */
// crosspoint setup editor: view image, source indicators, step indices
//
// Local design decisions: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ns
`include "editor_regs.svh"
////////////////////////////////////////////////////////////////////////////////
module crosspoint_setup_editor #(
  parameter int COLS = 72,
  parameter int NSET = 100,
  parameter int NOTICE_CYC = `NOTICE_MS * `CYC_PER_MS,
  parameter int REPEAT_CYC = `REPEAT_MS * `CYC_PER_MS,
  parameter int BLINK_CYC = `BLINK_MS * `CYC_PER_MS
) (
  // apb slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // keypad entry and keys
  input wire logic entry_valid,
  input wire logic [8:0] entry_num,
  input wire logic [2:0] entry_row,
  input wire logic entry_blk,
  input wire logic key_memory,
  input wire logic key_relays,
  input wire logic key_enter,
  input wire logic key_open,
  input wire logic key_close,
  input wire logic key_clear,
  input wire logic key_save,
  input wire logic key_apply,
  input wire logic key_auto,
  input wire logic key_mb,
  input wire logic key_bm,
  input wire logic scroll_up,
  input wire logic scroll_dn,
  // light pen
  input wire logic pen_press,
  input wire editor_pkg::pen_t pen_kind,
  input wire logic [2:0] pen_row,
  input wire logic pen_blk,
  input wire logic [8:0] pen_col,
  // outside changes of stored setups and relays
  input wire logic bus_mem_we,
  input wire logic [6:0] bus_mem_loc,
  input wire logic [8*COLS-1:0] bus_mem_data,
  input wire logic relay_load,
  input wire logic [8*COLS-1:0] relay_data,
  // image and indicators
  output logic [8*COLS-1:0] view,
  output logic [8*COLS-1:0] relays,
  output logic [15:0] mb_rows,
  output logic [15:0] bm_rows,
  output logic ind_mem,
  output logic ind_rly,
  output logic ind_edt,
  output logic ind_auto,
  output logic [6:0] mem_step,
  output logic [6:0] rly_step,
  output logic note_bad,
  output logic note_pen
);

  localparam int NB = 8 * COLS;
  localparam int BW = $clog2(NB);
  localparam logic [6:0] LOC_MAX = 7'(NSET);
  localparam logic [9:0] COLW = 10'(COLS);
  localparam logic [NB-1:0] ONE = NB'(1);

  editor_pkg::src_t src;
  editor_pkg::src_t next_src;
  logic [NB-1:0] mem [NSET];
  logic blink_edt;
  logic blink_ph;
  logic [2:0] units;
  logic [2:0] upos;
  logic up_q;
  logic dn_q;
  logic [31:0] rep_cnt;
  logic [31:0] note_cnt;
  logic [31:0] blink_cnt;

  function automatic logic [BW-1:0] xbit(input logic [2:0] r, input logic [9:0] c,
                                         input logic [9:0] b);
    xbit = BW'(32'(r) * COLS + 32'(c - b - 10'h001));
  endfunction : xbit

  ////////////////////////////////////////////////////////////////////////////////
  // scroll keys with hold repeat
  wire is_mem = src == editor_pkg::SRC_MEM;
  wire is_rly = src == editor_pkg::SRC_RLY;
  wire is_edt = src == editor_pkg::SRC_EDT;
  wire rep_hit = rep_cnt == 32'(REPEAT_CYC - 1);
  wire up_new = scroll_up & ~up_q;
  wire dn_new = scroll_dn & ~dn_q;
  wire step_up = scroll_up & ~scroll_dn & (up_new | rep_hit);
  wire step_dn = scroll_dn & ~scroll_up & (dn_new | rep_hit);
  wire do_up = step_up & ~is_edt;
  wire do_dn = step_dn & ~is_edt;
  wire do_step = do_up | do_dn;

  // stored index wraps past 000, applied index runs through it
  wire [6:0] s_up = (mem_step == LOC_MAX) ? `LOC_ONE : mem_step + `LOC_ONE;
  wire [6:0] s_dn = (mem_step == `LOC_ONE) ? LOC_MAX : mem_step - `LOC_ONE;
  wire [6:0] r_up = (rly_step == LOC_MAX) ? `LOC_ZERO : rly_step + `LOC_ONE;
  wire [6:0] r_dn = (rly_step == `LOC_ZERO) ? LOC_MAX : rly_step - `LOC_ONE;

  ////////////////////////////////////////////////////////////////////////////////
  // entered locations
  wire [6:0] ent_loc = entry_num[6:0];
  wire ent_rly_ok = ~(|entry_num[8:7]) & (ent_loc <= LOC_MAX);
  wire ent_mem_ok = ent_rly_ok & (ent_loc != `LOC_ZERO);

  wire ld_mem_key = key_memory & (~entry_valid | ent_mem_ok);
  wire ld_mem_ent = key_enter & is_mem & entry_valid & ent_mem_ok;
  wire ld_mem_scr = do_step & is_mem;
  wire ld_mem = ld_mem_key | ld_mem_ent | ld_mem_scr;
  wire [6:0] scr_loc = do_up ? s_up : s_dn;
  wire [6:0] mem_loc = ld_mem_scr ? scr_loc : (entry_valid ? ent_loc : mem_step);

  wire go_rly_key = key_relays & (~entry_valid | ent_rly_ok);
  wire go_rly_ent = key_enter & is_rly & entry_valid & ent_rly_ok;
  wire go_rly_scr = do_step & is_rly;
  wire go_rly_sel = go_rly_scr | (entry_valid & (go_rly_key | go_rly_ent));
  wire [6:0] rly_loc = go_rly_scr ? (do_up ? r_up : r_dn) : ent_loc;
  // location 000 names no setup, so the relays keep their state
  wire rly_fire = go_rly_sel & (rly_loc != `LOC_ZERO);

  wire [6:0] rd_loc = ld_mem ? mem_loc : rly_loc;
  wire rd_ok = (rd_loc != `LOC_ZERO) & (rd_loc <= LOC_MAX);
  // one read port serves memory key, enter, scroll and relay loads
  wire [NB-1:0] rd_data = rd_ok ? mem[rd_loc - `LOC_ONE] : '0;

  wire [6:0] sv_loc = entry_valid ? ent_loc : mem_step;
  wire sv_ok = key_save & (~entry_valid | ent_mem_ok);

  ////////////////////////////////////////////////////////////////////////////////
  // crosspoint addresses over the linked system, local slice only
  wire [9:0] max_col = 10'(units) * COLW;
  wire [9:0] base = 10'(upos) * COLW;
  wire [9:0] ecol = {1'b0, entry_num};
  wire [9:0] pcol = {1'b0, pen_col};
  wire addr_ok = entry_valid & (ecol != 10'h000) & (ecol <= max_col);
  wire pen_ok = (pcol != 10'h000) & (pcol <= max_col);
  wire ent_local = (ecol > base) & (ecol <= base + COLW);
  wire pen_local = (pcol > base) & (pcol <= base + COLW);
  wire [NB-1:0] ent_mask = ent_local ? (ONE << xbit(entry_row, ecol, base)) : '0;
  wire [NB-1:0] pen_mask = pen_local ? (ONE << xbit(pen_row, pcol, base)) : '0;

  wire ed_open = key_open & addr_ok;
  wire ed_close = key_close & addr_ok;
  wire pen_xp = pen_press & (pen_kind == editor_pkg::PEN_XP) & pen_ok;
  wire edit = ed_open | ed_close | key_clear | pen_xp;
  wire edit_blink = edit & ind_auto & is_rly;

  ////////////////////////////////////////////////////////////////////////////////
  // row marks
  wire pen_mb = pen_press & (pen_kind == editor_pkg::PEN_MB);
  wire pen_bm = pen_press & (pen_kind == editor_pkg::PEN_BM);
  wire mk_mb = (key_mb & entry_valid) | pen_mb;
  wire mk_bm = (key_bm & entry_valid) | pen_bm;
  wire [3:0] mk_idx = pen_press ? {pen_blk, pen_row} : {entry_blk, entry_row};
  wire [15:0] mk_bit = 16'h0001 << mk_idx;
  wire [15:0] mb_flip = mb_rows ^ mk_bit;
  wire [15:0] bm_flip = bm_rows ^ mk_bit;
  // turning one mark on clears the other mark of that row
  wire [15:0] next_mb = mk_mb ? mb_flip : (mk_bm & ~bm_rows[mk_idx]) ? mb_rows & ~mk_bit
                      : mb_rows;
  wire [15:0] next_bm = mk_bm ? bm_flip : (mk_mb & ~mb_rows[mk_idx]) ? bm_rows & ~mk_bit
                      : bm_rows;

  ////////////////////////////////////////////////////////////////////////////////
  // notices
  wire bad = (key_memory & entry_valid & ~ent_mem_ok)
           | (key_relays & entry_valid & ~ent_rly_ok)
           | (key_enter & entry_valid & ((is_mem & ~ent_mem_ok) | (is_rly & ~ent_rly_ok)))
           | (key_save & entry_valid & ~ent_mem_ok)
           | ((key_open | key_close) & ~addr_ok);
  wire pen_miss = pen_press & (((pen_kind == editor_pkg::PEN_MISS))
                | ((pen_kind == editor_pkg::PEN_XP) & ~pen_ok));
  wire note_done = (note_bad | note_pen) & (note_cnt == 32'h0000_0000);

  ////////////////////////////////////////////////////////////////////////////////
  // next view, relays and source
  // a save in the same cycle wins over the bus write
  wire bus_show = bus_mem_we & is_mem & (bus_mem_loc == mem_step) & ~sv_ok;
  wire [NB-1:0] next_view =
      key_clear ? '0 :
      ed_open ? (view & ~ent_mask) :
      ed_close ? (view | ent_mask) :
      pen_xp ? (view ^ pen_mask) :
      (ld_mem | rly_fire) ? rd_data :
      (go_rly_key | go_rly_sel) ? relays :
      bus_show ? bus_mem_data :
      (relay_load & is_rly) ? relay_data :
      view;
  // live-apply copies the view as it will stand after this edge
  wire auto_push = ind_auto & (edit | ld_mem);
  wire [NB-1:0] next_relays =
      rly_fire ? rd_data :
      key_apply ? view :
      auto_push ? next_view :
      relay_load ? relay_data :
      relays;
  wire [6:0] next_mstep = ld_mem ? mem_loc : (sv_ok ? sv_loc : mem_step);
  wire [6:0] next_rstep = go_rly_sel ? rly_loc :
                          (key_apply & is_mem) ? mem_step :
                          (ind_auto & ld_mem) ? mem_loc :
                          rly_step;

  // exactly one source code at a time
  assign next_src = edit ? (edit_blink ? editor_pkg::SRC_RLY : editor_pkg::SRC_EDT) :
                    ld_mem_key ? editor_pkg::SRC_MEM :
                    (go_rly_key | (key_apply & is_edt)) ? editor_pkg::SRC_RLY :
                    (sv_ok & is_edt) ? editor_pkg::SRC_MEM :
                    src;
  // blink lasts until a key or a relay step takes over the relays view
  wire blink_keep = blink_edt & is_rly & ~ld_mem_key & ~go_rly_key & ~key_apply & ~go_rly_sel;
  wire blink_tick = blink_cnt == 32'(BLINK_CYC - 1);

  ////////////////////////////////////////////////////////////////////////////////
  // apb decode
  wire a_setup = psel & ~penable;
  wire a_stat = paddr == `OFF_STATUS;
  wire a_unit = paddr == `OFF_UNITS;
  wire a_mark = paddr == `OFF_MARKS;
  wire a_hit = a_stat | a_unit | a_mark;
  // writes land in the access cycle; bad unit settings are dropped
  wire a_wr = psel & penable & pready & pwrite & a_unit;
  wire [2:0] w_units = pwdata[2:0];
  wire [2:0] w_upos = pwdata[6:4];
  wire w_ok = (w_units != 3'h0) & (w_units <= `UNITS_MAX) & (w_upos < w_units);
  wire [31:0] stat_word = {10'h000, note_pen, note_bad, ind_auto, is_edt, is_rly, is_mem,
                           1'b0, rly_step, 1'b0, mem_step};
  wire [31:0] rd_mux = a_stat ? stat_word
                     : a_unit ? {24'h00_0000, 1'b0, upos, 1'b0, units}
                     : a_mark ? {bm_rows, mb_rows}
                     : 32'h0000_0000;

  ////////////////////////////////////////////////////////////////////////////////
  // stored setups, one entry per location
  for (genvar i = 0; i < NSET; i++) begin : g_mem
    wire sv_hit = sv_ok & (sv_loc == 7'(i + 1));
    wire bus_hit = bus_mem_we & (bus_mem_loc == 7'(i + 1));
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        mem[i] <= '0;
      end else if (sv_hit) begin
        mem[i] <= view;
      end else if (bus_hit) begin
        mem[i] <= bus_mem_data;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // editor state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src <= editor_pkg::SRC_RLY;
      view <= '0;
      relays <= '0;
      mem_step <= `SIDX_RST;
      rly_step <= `RIDX_RST;
      ind_auto <= 1'b0;
      mb_rows <= 16'h0000;
      bm_rows <= 16'h0000;
      blink_edt <= 1'b0;
    end else begin
      src <= next_src;
      view <= next_view;
      relays <= next_relays;
      mem_step <= next_mstep;
      rly_step <= next_rstep;
      ind_auto <= ind_auto ^ key_auto;
      mb_rows <= next_mb;
      bm_rows <= next_bm;
      blink_edt <= edit_blink | blink_keep;
    end
  end

  // indicator drive, blink and scroll repeat
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ind_mem <= 1'b0;
      ind_rly <= 1'b1;
      ind_edt <= 1'b0;
      blink_ph <= 1'b0;
      blink_cnt <= 32'h0000_0000;
      up_q <= 1'b0;
      dn_q <= 1'b0;
      rep_cnt <= 32'h0000_0000;
    end else begin
      ind_mem <= is_mem;
      ind_rly <= is_rly;
      ind_edt <= is_edt | (blink_edt & blink_ph);
      blink_cnt <= blink_tick ? 32'h0000_0000 : blink_cnt + 32'h0000_0001;
      blink_ph <= blink_ph ^ blink_tick;
      up_q <= scroll_up;
      dn_q <= scroll_dn;
      rep_cnt <= (~(scroll_up | scroll_dn) | rep_hit | up_new | dn_new) ? 32'h0000_0000
               : rep_cnt + 32'h0000_0001;
    end
  end

  // brief notices, the newest replaces an older one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      note_bad <= 1'b0;
      note_pen <= 1'b0;
      note_cnt <= 32'h0000_0000;
    end else if (bad | pen_miss) begin
      note_bad <= bad;
      note_pen <= pen_miss & ~bad;
      note_cnt <= 32'(NOTICE_CYC - 1);
    end else if (note_done) begin
      note_bad <= 1'b0;
      note_pen <= 1'b0;
    end else if (note_bad | note_pen) begin
      note_cnt <= note_cnt - 32'h0000_0001;
    end
  end

  // apb slave, answers in the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      units <= `UNITS_RST;
      upos <= `UPOS_RST;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= a_setup;
      pslverr <= a_setup & ~a_hit;
      prdata <= (a_setup & ~pwrite) ? rd_mux : 32'h0000_0000;
      if (a_wr & w_ok) begin
        units <= w_units;
        upos <= w_upos;
      end
    end
  end

endmodule : crosspoint_setup_editor

/* verilog/editor_pkg.sv */
// types of the setup editor
package editor_pkg;
  typedef enum logic [2:0] {
    SRC_MEM = 3'b001,
    SRC_RLY = 3'b010,
    SRC_EDT = 3'b100
  } src_t;
  typedef enum logic [1:0] {
    PEN_MISS = 2'h0,
    PEN_XP = 2'h1,
    PEN_MB = 2'h2,
    PEN_BM = 2'h3
  } pen_t;
endpackage : editor_pkg

/* verilog/editor_regs.svh */
// register offsets, reset values and timing figures of the setup editor
`ifndef EDITOR_REGS_SVH
`define EDITOR_REGS_SVH
`define OFF_STATUS 12'h000
`define OFF_UNITS 12'h004
`define OFF_MARKS 12'h008
`define UNITS_RST 3'h1
`define UNITS_MAX 3'h5
`define UPOS_RST 3'h0
`define SIDX_RST 7'h01
`define RIDX_RST 7'h00
`define LOC_ZERO 7'h00
`define LOC_ONE 7'h01
`define CLK_HZ 50000000
`define CYC_PER_MS (`CLK_HZ / 1000)
`define NOTICE_MS 2000
`define REPEAT_MS 100
`define BLINK_MS 250
`endif
